// ===== include/rfpc_pkg.sv
package rfpc_pkg;
  // --------------------------------------------------------------------------
  // Clock and timing.
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned EN_FILT_NS = 250;
  localparam int unsigned EN_FILT_CYC = (EN_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OC_DELAY_US = 256;
  localparam int unsigned OC_DELAY_CYC = OC_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned OC_OFF_MS = 4;
  localparam int unsigned OC_OFF_CYC = OC_OFF_MS * (CLK_HZ / 1_000);
  localparam int unsigned PS1_DELAY_SW = 8;
  localparam int unsigned OPEN_LOOP_SW = 8;
  localparam int unsigned BUS_NAK_CLKS = 4;

  // --------------------------------------------------------------------------
  // Phase shed bands and reference codes.
  // --------------------------------------------------------------------------
  localparam logic [1:0] SHED_NONE = 2'h0;
  localparam logic [1:0] SHED_THREE = 2'h3;
  localparam logic [1:0] REF_NORMAL = 2'h0;
  localparam logic [1:0] REF_LOW_250MV = 2'h1;
  localparam logic [1:0] REF_TEST_1V = 2'h2;

  // Rail fault states.
  typedef enum logic [1:0] {RFPC_RUN, RFPC_SOFT, RFPC_HICCUP} rfpc_rail_t;
  // Power state.
  typedef enum logic [1:0] {RFPC_FULL, RFPC_WAIT, RFPC_LIGHT} rfpc_ps_t;
endpackage : rfpc_pkg

// ===== design/rfpc_sync.sv
`timescale 1ns/10ps
// Two flip-flop synchroniser for a vector of pin levels.
module rfpc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // --------------------------------------------------------------------------
  // Only the second stage is visible outside.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : rfpc_sync

// ===== design/rfpc_rail.sv
`timescale 1ns/10ps
// Fault manager for one output rail.
module rfpc_rail #(
  parameter int unsigned OC_DELAY = rfpc_pkg::OC_DELAY_CYC,
  parameter int unsigned OC_OFF = rfpc_pkg::OC_OFF_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic sw_tick_in,
  input wire logic en_ok_in,
  input wire logic en_rise_in,
  input wire logic uvlo_in,
  input wire logic ea_high_in,
  input wire logic ov_in,
  input wire logic oc_in,
  input wire logic sense_hiz_in,
  input wire logic sense_abn_in,
  input wire logic pre_power_in,
  input wire logic vout_uv_in,
  input wire logic bus_err_in,
  input wire logic peer_stop_in,
  input wire logic peer_hiccup_in,
  output logic latched_out,
  output logic stop_out,
  output logic hiccup_out,
  output logic ea_dis_out,
  output logic ready_n_out,
  output logic ov_out,
  output logic [1:0] ref_out
);
  logic [3:0] ol_cnt_q;
  logic ol_q, os_q, ov_q;
  logic [31:0] oc_cnt_q;
  rfpc_pkg::rfpc_rail_t st_q;
  logic peer_hic_q;
  wire soft_fault = ~en_ok_in | uvlo_in | peer_stop_in; // R11
  wire supply_fault = ol_q | os_q | ov_q;
  wire os_check = pre_power_in | sense_abn_in;

  // --------------------------------------------------------------------------
  // Latched faults; only reset (bias cycling) clears them, except over-voltage.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ol_cnt_q <= '0;
      ol_q <= 1'b0;
      os_q <= 1'b0;
      ov_q <= 1'b0;
    end else begin
      if (!ea_high_in) ol_cnt_q <= '0; // R19
      else if (sw_tick_in && ol_cnt_q < 4'(rfpc_pkg::OPEN_LOOP_SW)) ol_cnt_q <= ol_cnt_q + 4'h1;
      if (ol_cnt_q == 4'(rfpc_pkg::OPEN_LOOP_SW)) ol_q <= 1'b1; // R9
      if (os_check && sense_hiz_in) os_q <= 1'b1; // R20 R21
      if (ov_in) ov_q <= 1'b1; // Set wins over the enable clear.
      else if (en_rise_in) ov_q <= 1'b0; // R10
    end
  end

  // --------------------------------------------------------------------------
  // Over-current persistence and hiccup timing.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= rfpc_pkg::RFPC_RUN;
      oc_cnt_q <= '0;
      peer_hic_q <= 1'b0;
    end else begin
      peer_hic_q <= peer_hiccup_in;
      case (st_q)
        rfpc_pkg::RFPC_RUN: begin
          // Only the peer's entry into hiccup is followed; following its level would let
          // the two rails re-arm each other for ever.
          if (peer_hiccup_in && !peer_hic_q) begin
            st_q <= rfpc_pkg::RFPC_HICCUP; // R23
            oc_cnt_q <= '0;
          end else if (oc_in) begin
            oc_cnt_q <= oc_cnt_q + 32'h1;
            if (oc_cnt_q + 32'h1 >= OC_DELAY) begin
              st_q <= rfpc_pkg::RFPC_HICCUP; // R15
              oc_cnt_q <= '0;
            end
          end else oc_cnt_q <= '0;
        end
        rfpc_pkg::RFPC_HICCUP: begin
          oc_cnt_q <= oc_cnt_q + 32'h1;
          if (oc_cnt_q + 32'h1 >= OC_OFF) begin
            st_q <= rfpc_pkg::RFPC_RUN; // R15
            oc_cnt_q <= '0;
          end
        end
        default: st_q <= rfpc_pkg::RFPC_RUN;
      endcase
    end
  end

  wire hic = (st_q == rfpc_pkg::RFPC_HICCUP);
  wire ea_d = supply_fault | soft_fault | hic; // R12
  wire rdy_bad = ea_d | vout_uv_in; // R13
  wire [1:0] ref_d = (supply_fault | soft_fault | hic) ? rfpc_pkg::REF_LOW_250MV : rfpc_pkg::REF_NORMAL; // R14
  logic unused_bus;
  assign unused_bus = bus_err_in; // Bus faults leave ready and amplifier alone. R16

  // --------------------------------------------------------------------------
  // Registered outputs.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latched_out <= 1'b0;
      stop_out <= 1'b1;
      hiccup_out <= 1'b0;
      ea_dis_out <= 1'b1;
      ready_n_out <= 1'b1;
      ov_out <= 1'b0;
      ref_out <= rfpc_pkg::REF_LOW_250MV;
    end else begin
      latched_out <= supply_fault;
      stop_out <= supply_fault | soft_fault; // R23
      hiccup_out <= hic; // R23
      ea_dis_out <= ea_d;
      ready_n_out <= rdy_bad & ~unused_bus | rdy_bad;
      ov_out <= ov_q & ov_in; // R24
      ref_out <= ref_d;
    end
  end
endmodule : rfpc_rail

// ===== design/rfpc_top.sv
`timescale 1ns/10ps
// Contract
// R1 - Shed level band code selects none, one, two or three disabled phases.
// R2 - Shed level taken at power-up and followed while running.
// R3 - Switching clock divider rescales with active phase count.
// R4 - Integrator should not shed phases with external sync clock.
// R5 - Light-load command selects single-phase operation.
// R6 - Eight switching cycles pass before entering light-load state.
// R7 - Deep sleep state is not supported.
// R8 - Address strap high enters test mode booting to one volt.
// R9 - Open loop, open sense, over-voltage latched until reset.
// R10 - Over-voltage also cleared by enable rising again.
// R11 - Other faults self-clear when the condition goes away.
// R12 - Faults except bus and output undervoltage disable error amplifier.
// R13 - Faults except bus drop ready; ready returns when all clear.
// R14 - Reference goes to 250 mV on faults, unchanged on undervoltage.
// R15 - Over-current acts after 256 us, then 4 ms off hiccup.
// R16 - Bus fault answered with negative acknowledge four bus clocks later.
// R17 - Enable filtered for 250 ns against chatter.
// R18 - Enable low sets fault latch, enable high clears it.
// R19 - Error amplifier high for eight switching cycles latches open loop.
// R20 - Sense lines checked before power-up; high impedance latches fault.
// R21 - Abnormal sense environment repeats check while running.
// R22 - Fault handling duplicated for both rails.
// R23 - Latched, enable, lockout stop other rail; over-current hiccups both.
// R24 - Over-voltage indicator high only while over-voltage persists.
// R25 - Analog comparisons arrive as synchronised digital inputs.
module rfpc_top #(
  parameter int unsigned OC_DELAY = rfpc_pkg::OC_DELAY_CYC,
  parameter int unsigned OC_OFF = rfpc_pkg::OC_OFF_CYC,
  parameter int unsigned SW_DIV = 40
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [1:0] phase_shed_level_in,
  input wire logic light_load_cmd_in,
  input wire logic full_power_cmd_in,
  input wire logic addr_strap_in,
  input wire logic enable_in,
  input wire logic uvlo_in,
  input wire logic bus_clk_in,
  input wire logic [1:0] bus_err_in,
  input wire logic [1:0] ea_high_in,
  input wire logic [1:0] ov_in,
  input wire logic [1:0] oc_in,
  input wire logic [1:0] sense_hiz_in,
  input wire logic [1:0] sense_abn_in,
  input wire logic [1:0] vout_uv_in,
  output logic [1:0] shed_count_out,
  output logic sw_tick_out,
  output logic light_load_state_out,
  output logic test_mode_out,
  output logic [1:0] regulator_ready_out,
  output logic [1:0] ea_disable_out,
  output logic [1:0] overvoltage_indicator_out,
  output logic [1:0] rail_stop_out,
  output logic [3:0] reference_level_out,
  output logic bus_nak_out
);
  // --------------------------------------------------------------------------
  // Pin synchronisation.
  // --------------------------------------------------------------------------
  localparam int NS = 22;
  logic [NS-1:0] s;
  rfpc_sync #(.W(NS)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .async_in({phase_shed_level_in, light_load_cmd_in, full_power_cmd_in, addr_strap_in, enable_in, uvlo_in,
               bus_clk_in, bus_err_in, ea_high_in, ov_in, oc_in, sense_hiz_in, sense_abn_in, vout_uv_in}),
    .sync_out(s)
  ); // R25
  wire [1:0] shed_s = s[21:20];
  wire ll_s = s[19];
  wire fp_s = s[18];
  wire strap_s = s[17];
  wire en_s = s[16];
  wire uvlo_s = s[15];
  wire bclk_s = s[14];
  wire [1:0] berr_s = s[13:12];
  wire [1:0] eah_s = s[11:10];
  wire [1:0] ov_s = s[9:8];
  wire [1:0] oc_s = s[7:6];
  wire [1:0] hiz_s = s[5:4];
  wire [1:0] abn_s = s[3:2];
  wire [1:0] uv_s = s[1:0];

  // --------------------------------------------------------------------------
  // Enable filter: level must hold for the blank time before it is taken.
  // --------------------------------------------------------------------------
  logic [3:0] en_cnt_q;
  logic en_f_q, en_prev_q, pre_q, strap_done_q;
  wire en_rise = en_f_q & ~en_prev_q;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_cnt_q <= '0;
      en_f_q <= 1'b0;
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_f_q;
      if (en_s == en_f_q) en_cnt_q <= '0; // R17
      else if (en_cnt_q + 4'h1 >= 4'(rfpc_pkg::EN_FILT_CYC)) begin
        en_f_q <= en_s; // R18
        en_cnt_q <= '0;
      end else en_cnt_q <= en_cnt_q + 4'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Shed decode, sampled at power-up and followed thereafter.
  // --------------------------------------------------------------------------
  logic [1:0] shed_q;
  logic ps_light;
  wire [1:0] shed_d = ps_light ? rfpc_pkg::SHED_THREE : shed_s; // R1 R5
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shed_q <= rfpc_pkg::SHED_NONE;
      pre_q <= 1'b1;
      strap_done_q <= 1'b0;
      test_mode_out <= 1'b0;
    end else begin
      shed_q <= shed_d; // R2
      if (en_f_q) pre_q <= 1'b0; // Sense check window closes at power-up.
      // The strap is taken at the first filtered enable, once the synchroniser holds its real level.
      if (!strap_done_q && en_f_q) begin
        strap_done_q <= 1'b1;
        test_mode_out <= strap_s; // R8
      end
    end
  end

  // --------------------------------------------------------------------------
  // Switching clock: the per-phase period scales with active phase count.
  // --------------------------------------------------------------------------
  logic [15:0] div_q;
  wire [15:0] div_lim = 16'(SW_DIV * (4 - int'(shed_q))); // R3
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q <= '0;
      sw_tick_out <= 1'b0;
    end else begin
      sw_tick_out <= (div_q + 16'h1 >= div_lim);
      div_q <= (div_q + 16'h1 >= div_lim) ? 16'h0 : div_q + 16'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Power state: only full and light-load; deep sleep is never entered.
  // --------------------------------------------------------------------------
  rfpc_pkg::rfpc_ps_t ps_q;
  logic [3:0] ps_cnt_q;
  assign ps_light = (ps_q == rfpc_pkg::RFPC_LIGHT);
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ps_q <= rfpc_pkg::RFPC_FULL;
      ps_cnt_q <= '0;
    end else begin
      case (ps_q)
        rfpc_pkg::RFPC_FULL: if (ll_s) begin
          ps_q <= rfpc_pkg::RFPC_WAIT; // R5
          ps_cnt_q <= '0;
        end
        rfpc_pkg::RFPC_WAIT: if (fp_s) ps_q <= rfpc_pkg::RFPC_FULL;
        else if (sw_tick_out) begin
          ps_cnt_q <= ps_cnt_q + 4'h1;
          if (ps_cnt_q + 4'h1 >= 4'(rfpc_pkg::PS1_DELAY_SW)) ps_q <= rfpc_pkg::RFPC_LIGHT; // R6
        end
        rfpc_pkg::RFPC_LIGHT: if (fp_s) ps_q <= rfpc_pkg::RFPC_FULL; // R7
        default: ps_q <= rfpc_pkg::RFPC_FULL;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Bus fault: negative acknowledge after four bus clock rising edges.
  // --------------------------------------------------------------------------
  logic bclk_prev_q;
  logic [2:0] nak_cnt_q;
  logic nak_busy_q;
  wire bclk_rise = bclk_s & ~bclk_prev_q;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bclk_prev_q <= 1'b0;
      nak_cnt_q <= '0;
      nak_busy_q <= 1'b0;
      bus_nak_out <= 1'b0;
    end else begin
      bclk_prev_q <= bclk_s;
      bus_nak_out <= 1'b0;
      if (!nak_busy_q && |berr_s) begin
        nak_busy_q <= 1'b1;
        nak_cnt_q <= '0;
      end else if (nak_busy_q && bclk_rise) begin
        nak_cnt_q <= nak_cnt_q + 3'h1;
        if (nak_cnt_q + 3'h1 >= 3'(rfpc_pkg::BUS_NAK_CLKS)) begin
          bus_nak_out <= 1'b1; // R16
          nak_busy_q <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Two rail fault managers with cross-rail stop and hiccup.
  // --------------------------------------------------------------------------
  logic [1:0] stop_w, hic_w, eadis_w, rdyn_w, ov_w, lat_w;
  logic [1:0] ref_w [2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_rail
      rfpc_rail #(.OC_DELAY(OC_DELAY), .OC_OFF(OC_OFF)) u_rail (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .sw_tick_in(sw_tick_out),
        .en_ok_in(en_f_q),
        .en_rise_in(en_rise),
        .uvlo_in(uvlo_s),
        .ea_high_in(eah_s[g]),
        .ov_in(ov_s[g]),
        .oc_in(oc_s[g]),
        .sense_hiz_in(hiz_s[g]),
        .sense_abn_in(abn_s[g]),
        .pre_power_in(pre_q),
        .vout_uv_in(uv_s[g]),
        .bus_err_in(berr_s[g]),
        .peer_stop_in(lat_w[1-g]),
        .peer_hiccup_in(hic_w[1-g]),
        .latched_out(lat_w[g]),
        .stop_out(stop_w[g]),
        .hiccup_out(hic_w[g]),
        .ea_dis_out(eadis_w[g]),
        .ready_n_out(rdyn_w[g]),
        .ov_out(ov_w[g]),
        .ref_out(ref_w[g])
      ); // R22 R23
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Top outputs registered once more.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shed_count_out <= rfpc_pkg::SHED_NONE;
      light_load_state_out <= 1'b0;
      regulator_ready_out <= '0;
      ea_disable_out <= 2'h3;
      overvoltage_indicator_out <= '0;
      rail_stop_out <= 2'h3;
      reference_level_out <= {rfpc_pkg::REF_LOW_250MV, rfpc_pkg::REF_LOW_250MV};
    end else begin
      shed_count_out <= shed_q;
      light_load_state_out <= ps_light;
      regulator_ready_out <= ~rdyn_w; // R13
      ea_disable_out <= eadis_w;
      overvoltage_indicator_out <= ov_w;
      rail_stop_out <= stop_w | hic_w;
      reference_level_out <= test_mode_out && !(|lat_w) ? {rfpc_pkg::REF_TEST_1V, rfpc_pkg::REF_TEST_1V}
                                                         : {ref_w[1], ref_w[0]}; // R8 R14
    end
  end

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------
  a_ov_latch_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    g_rail[0].u_rail.ov_q && !en_rise |=> g_rail[0].u_rail.ov_q) else $error("ov latch lost"); // R9
  a_ready_low_ea: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    eadis_w[0] |=> !regulator_ready_out[0]) else $error("ready high in fault"); // R13
  a_nak_after_err: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    bus_nak_out |-> $past(nak_busy_q)) else $error("nak without error"); // R16
  a_light_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(ps_light) |-> $past(ps_q) == rfpc_pkg::RFPC_WAIT) else $error("light without wait"); // R6
  a_light_shed: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    ps_light |=> shed_q == rfpc_pkg::SHED_THREE) else $error("light not single phase"); // R5
  a_ov_ind: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    overvoltage_indicator_out[0] |-> $past(ov_s[0], 2)) else $error("ov indicator"); // R24
  a_en_filter: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $changed(en_f_q) |-> $past(en_s, 2) == en_f_q) else $error("enable unfiltered"); // R17
  a_hic_both: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(hic_w[0]) |=> ##[0:2] hic_w[1] || !hic_w[0]) else $error("peer not in hiccup"); // R23
  c_light: cover property (@(posedge clk_sys_in) ps_light);
  c_nak: cover property (@(posedge clk_sys_in) bus_nak_out);
  c_hiccup: cover property (@(posedge clk_sys_in) hic_w[0]);
endmodule : rfpc_top

// ===== verif/rfpc_host.sv
`timescale 1ns/10ps
// Host side of the power-state bus: power-state requests, the bus clock and per-rail fault flags.
module rfpc_host (
  input wire logic clk_sys_in,
  output logic light_load_cmd_out,
  output logic full_power_cmd_out,
  output logic bus_clk_out,
  output logic [1:0] bus_err_out
);
  // Idle: full power requested, bus clock parked low, no fault flagged.
  initial begin
    light_load_cmd_out = 1'b0;
    full_power_cmd_out = 1'b1;
    bus_clk_out = 1'b0;
    bus_err_out = 2'h0;
  end

  // Only the two supported states are ever requested; the host never drives an external sync clock.
  task automatic send_state(input logic light);
    @(posedge clk_sys_in);
    #2;
    light_load_cmd_out = light;
    full_power_cmd_out = ~light;
  endtask : send_state

  // A faulty frame: the bus clock runs only while the frame lasts, then parks again.
  task automatic bus_frame(input logic [1:0] rails);
    @(posedge clk_sys_in);
    #2;
    bus_err_out = rails;
    repeat (12) begin
      repeat (2) @(posedge clk_sys_in);
      #2;
      bus_clk_out = ~bus_clk_out;
    end
    bus_err_out = 2'h0;
  endtask : bus_frame
endmodule : rfpc_host

// ===== verif/rfpc_top_test.sv
`timescale 1ns/10ps
module rfpc_top_test;
  // Short fault timings keep the hiccup scenarios to a few hundred cycles.
  localparam int unsigned SIM_OC_DELAY = 20;
  localparam int unsigned SIM_OC_OFF = 50;
  localparam int unsigned SIM_SW_DIV = 4;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] phase_shed_level_in = 2'h0;
  logic addr_strap_in = 1'b0;
  logic enable_in = 1'b0;
  logic uvlo_in = 1'b0;
  logic [1:0] ea_high_in = 2'h0, ov_in = 2'h0, oc_in = 2'h0, sense_hiz_in = 2'h0, sense_abn_in = 2'h0;
  logic [1:0] vout_uv_in = 2'h0, bus_err_in, shed_count_out, regulator_ready_out, ea_disable_out;
  logic [1:0] overvoltage_indicator_out, rail_stop_out;
  logic light_load_cmd_in, full_power_cmd_in, bus_clk_in, sw_tick_out, light_load_state_out;
  logic test_mode_out, bus_nak_out;
  logic [3:0] reference_level_out;
  int error_cnt = 0;
  int compares = 0;
  int nak_cnt = 0;
  int n;

  always #10 clk_sys_in = ~clk_sys_in;

  rfpc_top #(.OC_DELAY(SIM_OC_DELAY), .OC_OFF(SIM_OC_OFF), .SW_DIV(SIM_SW_DIV)) i_rfpc_top (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .phase_shed_level_in(phase_shed_level_in),
    .light_load_cmd_in(light_load_cmd_in), .full_power_cmd_in(full_power_cmd_in),
    .addr_strap_in(addr_strap_in), .enable_in(enable_in), .uvlo_in(uvlo_in), .bus_clk_in(bus_clk_in),
    .bus_err_in(bus_err_in), .ea_high_in(ea_high_in), .ov_in(ov_in), .oc_in(oc_in),
    .sense_hiz_in(sense_hiz_in), .sense_abn_in(sense_abn_in), .vout_uv_in(vout_uv_in),
    .shed_count_out(shed_count_out), .sw_tick_out(sw_tick_out), .light_load_state_out(light_load_state_out),
    .test_mode_out(test_mode_out), .regulator_ready_out(regulator_ready_out),
    .ea_disable_out(ea_disable_out), .overvoltage_indicator_out(overvoltage_indicator_out),
    .rail_stop_out(rail_stop_out), .reference_level_out(reference_level_out), .bus_nak_out(bus_nak_out));

  rfpc_host i_rfpc_host (
    .clk_sys_in(clk_sys_in), .light_load_cmd_out(light_load_cmd_in), .full_power_cmd_out(full_power_cmd_in),
    .bus_clk_out(bus_clk_in), .bus_err_out(bus_err_in));

  // Counts one-cycle refusal pulses so a short pulse cannot slip between checks.
  always @(posedge clk_sys_in) begin
    if (bus_nak_out === 1'b1) nak_cnt <= nak_cnt + 1;
  end

  // ---------------------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Inputs always move 2 ns after a rising edge so they never race the sampling edge.
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_in);
    #2;
  endtask : cyc

  // Returns the cycles to the next switching tick; samples 1 ns after the edge.
  task automatic next_tick(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      cnt++;
    end while (sw_tick_out !== 1'b1);
    #1;
  endtask : next_tick

  task automatic ticks(input int k);
    int c;
    repeat (k) next_tick(c);
  endtask : ticks

  task automatic stop_test();
    $display("Counts: error_cnt=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  // Status group: {ready, error amp disable, rail stop, over-voltage indicator}.
  function automatic logic [7:0] stat();
    return {regulator_ready_out, ea_disable_out, rail_stop_out, overvoltage_indicator_out};
  endfunction : stat

  // The whole sequence needs roughly 1300 cycles; this limit is generous.
  initial begin
    #400_000;
    error_cnt++;
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  initial begin
    cyc(5);
    chk(stat(), 8'h3C);
    chk({reference_level_out, shed_count_out, light_load_state_out, test_mode_out}, 8'h50);
    cyc(5);
    rst_n_in = 1'b1;
    enable_in = 1'b1;
    cyc(40);
    chk(stat(), 8'hC0);
    chk({4'h0, reference_level_out}, 8'h00);
    // A 60 ns dip is shorter than the enable filter and must be ignored.
    enable_in = 1'b0;
    cyc(3);
    enable_in = 1'b1;
    cyc(20);
    chk(stat(), 8'hC0);
    // Every shed band, changed while running, with the tick period rescaled.
    for (int s = 0; s < 4; s++) begin
      phase_shed_level_in = 2'(s);
      cyc(6);
      chk({6'h0, shed_count_out}, 8'(s));
      ticks(2);
      next_tick(n);
      chk(8'(n), 8'(SIM_SW_DIV * (4 - s)));
    end
    phase_shed_level_in = 2'h0;
    i_rfpc_host.send_state(1'b1);
    ticks(6);
    chk({7'h0, light_load_state_out}, 8'h00);
    ticks(4);
    chk({5'h0, light_load_state_out, shed_count_out}, 8'h07);
    i_rfpc_host.send_state(1'b0);
    cyc(8);
    chk({5'h0, light_load_state_out, shed_count_out}, 8'h00);
    // Bus fault: refusal pulse only, ready and error amp untouched, other rail runs.
    nak_cnt = 0;
    i_rfpc_host.bus_frame(2'b01);
    cyc(5);
    chk(8'(nak_cnt != 0), 8'h01);
    chk(stat(), 8'hC0);
    // Over-voltage on the first output: latched, indicator follows the condition.
    ov_in = 2'b01;
    cyc(10);
    chk(stat(), 8'h3D);
    chk({4'h0, reference_level_out}, 8'h05);
    ov_in = 2'b00;
    cyc(20);
    chk(stat(), 8'h3C);
    enable_in = 1'b0;
    cyc(30);
    chk({regulator_ready_out, rail_stop_out}, 8'h03);
    enable_in = 1'b1;
    cyc(40);
    chk(stat(), 8'hC0);
    // Lockout stops both rails and clears by itself.
    uvlo_in = 1'b1;
    cyc(10);
    chk({regulator_ready_out, rail_stop_out}, 8'h03);
    uvlo_in = 1'b0;
    cyc(40);
    chk(stat(), 8'hC0);
    vout_uv_in = 2'b01;
    cyc(10);
    chk({ea_disable_out, rail_stop_out, reference_level_out}, 8'h00);
    chk({6'h0, regulator_ready_out}, 8'h02);
    vout_uv_in = 2'b00;
    cyc(10);
    // Over-current shorter than the delay is ignored; a long one hiccups both rails.
    oc_in = 2'b10;
    cyc(SIM_OC_DELAY / 2);
    oc_in = 2'b00;
    cyc(10);
    chk(stat(), 8'hC0);
    oc_in = 2'b10;
    cyc(SIM_OC_DELAY + 10);
    chk({ea_disable_out[1], regulator_ready_out, rail_stop_out}, 8'h13);
    oc_in = 2'b00;
    cyc(SIM_OC_OFF + 100);
    chk(stat(), 8'hC0);
    // Open loop: seven ticks high is tolerated, a longer run latches.
    ea_high_in = 2'b10;
    ticks(7);
    ea_high_in = 2'b00;
    cyc(10);
    chk(stat(), 8'hC0);
    ea_high_in = 2'b10;
    ticks(11);
    ea_high_in = 2'b00;
    cyc(20);
    chk({ea_disable_out[1], regulator_ready_out, rail_stop_out}, 8'h13);
    // Only a bias cycle clears it; the sense lines are open across the release.
    sense_hiz_in = 2'b10;
    rst_n_in = 1'b0;
    cyc(10);
    rst_n_in = 1'b1;
    cyc(40);
    sense_hiz_in = 2'b00;
    cyc(20);
    chk({regulator_ready_out, rail_stop_out}, 8'h03);
    rst_n_in = 1'b0;
    cyc(10);
    rst_n_in = 1'b1;
    cyc(40);
    chk(stat(), 8'hC0);
    sense_abn_in = 2'b01;
    sense_hiz_in = 2'b01;
    cyc(20);
    sense_abn_in = 2'b00;
    sense_hiz_in = 2'b00;
    cyc(20);
    chk({regulator_ready_out, rail_stop_out}, 8'h03);
    // Strap high at reset boots both rails to the test level.
    addr_strap_in = 1'b1;
    rst_n_in = 1'b0;
    cyc(10);
    rst_n_in = 1'b1;
    cyc(40);
    chk({3'h0, test_mode_out, reference_level_out}, 8'h1A);
    stop_test();
  end
endmodule : rfpc_top_test
